// ===== design/dtc_consts.svh
// Offsets, field positions, reset values and clock figures of the counters
// Assumes inclusion from the package only
`ifndef DTC_CONSTS_SVH
`define DTC_CONSTS_SVH
`define DTC_IDX_C0_UPPER   5'h0C
`define DTC_IDX_C0_LOWER   5'h0D
`define DTC_IDX_C0_CTRL    5'h0E
`define DTC_IDX_C1_UPPER   5'h0F
`define DTC_IDX_C1_LOWER   5'h10
`define DTC_IDX_C1_CTRL    5'h11
`define DTC_IDX_STATUS     5'h12
`define DTC_BIT_EDGE       3
`define DTC_BIT_RUN        4
`define DTC_MODE_HI        7
`define DTC_MODE_LO        6
`define DTC_CTRL_RESET     8'h08
`define DTC_CTRL_MASK      8'hD8
`define DTC_TERMINAL       16'hFFFF
`define DTC_ZERO16         16'h0000
`define DTC_ZERO8          8'h00
`define DTC_SYS_HZ         50000000
`define DTC_INSTR_DIV      4
`define DTC_SLOW_HZ        32768
`define DTC_ACC_BITS       32
`endif

// ===== design/dtc_pkg.sv
// Types shared by the dual counter design
// Assumes dtc_consts.svh on the include path
package dtc_pkg;
`include "dtc_consts.svh"
	typedef enum logic [1:0] {
		MODE_NONE,
		MODE_EVENT,
		MODE_TIMER,
		MODE_PULSE
	} dtc_mode_t;
	typedef enum logic [1:0] {
		PW_IDLE,
		PW_ARMED,
		PW_COUNT
	} dtc_pw_t;
	typedef struct packed {
		logic [15:0] count;
		logic [15:0] preload;
		logic [7:0]  lowBuf;
		logic [7:0]  ctrl;
		dtc_pw_t     pw;
		logic        pinSync1;
		logic        pinSync2;
		logic        pinPrev;
		logic        flag;
	} dtc_unit_t;
	typedef struct packed {
		logic [4:0]  address;
		logic        read;
		logic        write;
		logic [7:0]  writedata;
	} dtc_bus_t;
	typedef struct packed {
		dtc_unit_t [1:0]           unit;
		logic [1:0]                instrDiv;
		logic [`DTC_ACC_BITS-1:0]  slowAcc;
		logic [7:0]                readdata;
		logic                      waitrequest;
		logic                      busDone;
		logic [1:0]                irq;
		logic                      wake;
	} dtc_state_t;
endpackage

// ===== design/dtc_dual_counter.sv
// Two 16-bit timer/event counters behind an Avalon-MM byte register slave
// Assumes one 50 MHz clock, synchronous active-low reset, async pins
// Summary of operation
// - Two independent 16-bit up counters, selectable clocks
// - Counter zero internal clock is clk over four
// - Counter one internal clock is 32768Hz tick
// - Low byte write fills buffer only
// - High byte write loads whole preload at once
// - High read latches low count; low reads buffer
// - Bit 3 picks edge or pulse polarity
// - Bit 4 runs counter; hardware may clear
// - Bits 0-2 and 5 read zero
// - Bits 7:6 pick event, timer, pulse mode
// - Event mode counts selected pin edges
// - Count up toward FFFFH while running
// - Overflow reloads preload and sets flag
// - Pulse mode counts between edge and return
// - One measurement, then hold until rerun
// - Pulse start needs an edge, not level
// - Pulse overflow reloads, flags, keeps measuring
// - Event and timer modes never self-clear run
// - Overflow raises wake-up output
// - Interrupt enable low blocks overflow request
// - Stopped counter loads with preload write
`timescale 1ns/1ps
module dtc_dual_counter
	import dtc_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic [4:0]  address,
	input  wire logic        read,
	input  wire logic        write,
	input  wire logic [7:0]  writedata,
	output logic      [7:0]  readdata,
	output logic             waitrequest,
	input  wire logic [1:0]  countPin,
	input  wire logic [1:0]  irqEnable,
	input  wire logic [1:0]  flagClear,
	output logic      [1:0]  overflowFlag,
	output logic      [1:0]  irqRequest,
	output logic             wakeup
);
	import dtc_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// Slow tick comes from a phase accumulator; jitter of one clk is
	// accepted in exchange for needing no second clock domain
	localparam logic [`DTC_ACC_BITS-1:0] SLOW_STEP =
		`DTC_ACC_BITS'((64'(`DTC_SLOW_HZ) << `DTC_ACC_BITS) / `DTC_SYS_HZ);
	localparam logic [1:0] DIV_LAST = 2'(`DTC_INSTR_DIV - 1);

	dtc_state_t state;
	dtc_state_t next_state;

	function automatic dtc_mode_t modeOf(input logic [7:0] c);
		unique case (c[`DTC_MODE_HI:`DTC_MODE_LO])
			2'h1: modeOf = MODE_EVENT;
			2'h2: modeOf = MODE_TIMER;
			2'h3: modeOf = MODE_PULSE;
			2'h0: modeOf = MODE_NONE;
		endcase
	endfunction

	function automatic logic [4:0] idxOf(input int u, input int k);
		logic [4:0] base;
		base = (u == 0) ? `DTC_IDX_C0_UPPER : `DTC_IDX_C1_UPPER;
		idxOf = base + 5'(k);
	endfunction

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		logic        tick;
		logic        slowTick;
		logic [`DTC_ACC_BITS:0] accSum;
		logic        accept;
		logic        rise;
		logic        fall;
		logic        actEdge;
		logic        retEdge;
		logic        inc;
		logic        running;
		logic        ovf;
		dtc_mode_t   md;
		dtc_unit_t   cu;
		next_state = state;
		tick = 1'b0;
		rise = 1'b0;
		fall = 1'b0;
		actEdge = 1'b0;
		retEdge = 1'b0;
		inc = 1'b0;
		running = 1'b0;
		ovf = 1'b0;
		md = MODE_NONE;
		cu = state.unit[0];
		slowTick = 1'b0;
		accSum = '0;
		accept = 1'b0;

		next_state.instrDiv = state.instrDiv + 2'h1;
		accSum = {1'b0, state.slowAcc} + {1'b0, SLOW_STEP};
		next_state.slowAcc = accSum[`DTC_ACC_BITS-1:0];
		slowTick = accSum[`DTC_ACC_BITS];

		// Accept one access per request; waitrequest drops for one cycle
		next_state.waitrequest = 1'b1;
		next_state.busDone = 1'b0;
		accept = (read || write) && !state.busDone;
		if (accept) begin
			next_state.waitrequest = 1'b0;
			next_state.busDone = 1'b1;
			next_state.readdata = `DTC_ZERO8;
		end
		next_state.wake = 1'b0;

		for (int u = 0; u < 2; u++) begin
			cu = state.unit[u];
			md = modeOf(cu.ctrl);
			cu.pinSync1 = countPin[u];
			cu.pinSync2 = state.unit[u].pinSync1;
			cu.pinPrev = state.unit[u].pinSync2;
			rise = state.unit[u].pinSync2 && !state.unit[u].pinPrev;
			fall = !state.unit[u].pinSync2 && state.unit[u].pinPrev;
			actEdge = cu.ctrl[`DTC_BIT_EDGE] ? fall : rise;
			retEdge = cu.ctrl[`DTC_BIT_EDGE] ? rise : fall;
			// Pulse polarity: edge 1 = high pulse, so start on rise
			if (md == MODE_PULSE) begin
				actEdge = cu.ctrl[`DTC_BIT_EDGE] ? rise : fall;
				retEdge = cu.ctrl[`DTC_BIT_EDGE] ? fall : rise;
			end
			tick = (u == 0) ? (state.instrDiv == DIV_LAST) : slowTick;
			running = cu.ctrl[`DTC_BIT_RUN];

			unique case (md)
				MODE_EVENT: inc = running && actEdge;
				MODE_TIMER: inc = running && tick;
				MODE_PULSE: begin
					inc = 1'b0;
					unique case (cu.pw)
						PW_IDLE: begin
							// Arm only on a fresh run; level alone never starts
							if (running) begin
								cu.pw = PW_ARMED;
							end
						end
						PW_ARMED: begin
							if (!running) begin
								cu.pw = PW_IDLE;
							end else if (actEdge) begin
								cu.pw = PW_COUNT;
							end
						end
						PW_COUNT: begin
							inc = tick;
							if (!running) begin
								cu.pw = PW_IDLE;
								inc = 1'b0;
							end else if (retEdge) begin
								// Stop, hold result, await new run
								cu.ctrl[`DTC_BIT_RUN] = 1'b0;
								cu.pw = PW_IDLE;
								inc = 1'b0;
							end
						end
					endcase
				end
				MODE_NONE: inc = 1'b0;
			endcase
			if (md != MODE_PULSE) begin
				cu.pw = PW_IDLE;
			end

			ovf = inc && (cu.count == `DTC_TERMINAL);
			if (ovf) begin
				cu.count = cu.preload;
			end else if (inc) begin
				cu.count = cu.count + 16'h0001;
			end
			if (flagClear[u]) begin
				cu.flag = 1'b0;
			end
			if (ovf) begin
				cu.flag = 1'b1;
				next_state.wake = 1'b1;
			end

			if (accept && write) begin
				if (address == idxOf(u, 1)) begin
					cu.lowBuf = writedata;
				end else if (address == idxOf(u, 0)) begin
					cu.preload = {writedata, cu.lowBuf};
					if (!cu.ctrl[`DTC_BIT_RUN]) begin
						cu.count = {writedata, cu.lowBuf};
					end
				end else if (address == idxOf(u, 2)) begin
					cu.ctrl = writedata & `DTC_CTRL_MASK;
					if (!writedata[`DTC_BIT_RUN]) begin
						cu.pw = PW_IDLE;
					end
				end
			end
			if (accept && read) begin
				// Software must read upper first for a coherent pair
				if (address == idxOf(u, 0)) begin
					next_state.readdata = state.unit[u].count[15:8];
					cu.lowBuf = state.unit[u].count[7:0];
				end else if (address == idxOf(u, 1)) begin
					next_state.readdata = state.unit[u].lowBuf;
				end else if (address == idxOf(u, 2)) begin
					next_state.readdata = state.unit[u].ctrl
						& `DTC_CTRL_MASK;
				end
			end
			next_state.unit[u] = cu;
			next_state.irq[u] = cu.flag && irqEnable[u];
		end
		if (accept && read && address == `DTC_IDX_STATUS) begin
			next_state.readdata = {6'h00, state.unit[1].flag,
				state.unit[0].flag};
		end
	end

	////////////////////////////////////////////////////////////////////////
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state <= '0;
			state.waitrequest <= 1'b1;
			for (int u = 0; u < 2; u++) begin
				state.unit[u].ctrl <= `DTC_CTRL_RESET;
				state.unit[u].count <= `DTC_ZERO16;
				state.unit[u].preload <= `DTC_ZERO16;
			end
		end else begin
			state <= next_state;
		end
	end

	assign readdata = state.readdata;
	assign waitrequest = state.waitrequest;
	assign overflowFlag = {state.unit[1].flag, state.unit[0].flag};
	assign irqRequest = state.irq;
	assign wakeup = state.wake;
endmodule

// ===== bench/dtc_properties.sv
// Port checker of the dual counter block
// Assumes a bind onto dtc_dual_counter, ports matched by name
`timescale 1ns/1ps
module dtc_properties(
	input wire logic       clk,
	input wire logic       rst_n,
	input wire logic [4:0] address,
	input wire logic       read,
	input wire logic       write,
	input wire logic [7:0] readdata,
	input wire logic       waitrequest,
	input wire logic [1:0] irqEnable,
	input wire logic [1:0] flagClear,
	input wire logic [1:0] overflowFlag,
	input wire logic [1:0] irqRequest,
	input wire logic       wakeup
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	// Request follows the new flag at once, gated by last cycle's enable
	a_irq_gate: assert property (
		irqRequest == (overflowFlag & $past(irqEnable)))
		else $error("request not flag and enable");
	a_flag_wake: assert property ($rose(overflowFlag[0]) |-> wakeup)
		else $error("overflow without wake pulse");
	a_flag_hold: assert property (overflowFlag[1] && !flagClear[1]
		|=> overflowFlag[1]) else $error("flag dropped");
	a_flag_clear: assert property (flagClear[0]
		|=> !overflowFlag[0] || wakeup) else $error("flag kept");
	a_wait_one: assert property (!waitrequest |=> waitrequest)
		else $error("answer longer than one cycle");
	a_bus_answer: assert property ($rose(read || write) |-> ##[1:3]
		!waitrequest) else $error("no answer");
	// Control reads must mask the unused bits, both units
	a_ctrl_zero: assert property (read && !waitrequest && (address == 5'h0E
		|| address == 5'h11) |-> (readdata & 8'h27) == 8'h00)
		else $error("unused control bits set");
	a_unmapped_zero: assert property (read && !waitrequest && address > 5'h12
		|-> readdata == 8'h00) else $error("unmapped read not zero");
	cover property (wakeup);
	cover property (irqRequest[0]);
	cover property (read && !waitrequest && address == 5'h12);
endmodule
bind dtc_dual_counter dtc_properties dtc_properties_i(.*);

// ===== bench/dtc_pin_model.sv
// External event source driving both counter pins
// Assumes the bench calls its tasks; changes follow rising edges
`timescale 1ns/1ps
module dtc_pin_model(
	input wire logic       clk,
	output logic     [1:0] countPin
);
	initial countPin = 2'b00;
	// Whole pulses only, level held between them
	task automatic pulse(input int u, input int w);
		@(posedge clk) countPin[u] <= ~countPin[u];
		repeat (w) @(posedge clk);
		countPin[u] <= ~countPin[u];
		repeat (w) @(posedge clk);
	endtask
	task automatic level(input int u, input logic v);
		@(posedge clk) countPin[u] <= v;
	endtask
endmodule

// ===== bench/dtc_dual_counter_bench.sv
// Self-checking bench of the dual counter block
// Assumes the pin model and the bound checker
`timescale 1ns/1ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin err_total++; \
	$display("[ERR] %0t got %h exp %h", $time, g, e); end end
module dtc_dual_counter_bench;
	import dtc_pkg::*;
	logic       clk = 0, rst_n = 0, read = 0, write = 0, waitrequest, wakeup;
	logic [4:0] address = 5'h00;
	logic [7:0] writedata = 8'h00, readdata, got, lo, hi, v;
	logic [1:0] irqEnable = 2'b00, flagClear = 2'b00, countPin;
	logic [1:0] overflowFlag, irqRequest;
	logic [7:0] expQ[$], mskQ[$];
	int         err_total = 0, checks_done = 0, n, k;
	dtc_dual_counter dtc_dual_counter_i(.*);
	dtc_pin_model    dtc_pin_model_i(.clk, .countPin);
	initial forever #10 clk = ~clk;
	// Read results are judged here, against the oldest note
	always @(posedge clk) if (read && !waitrequest) begin
		`CHK(readdata & mskQ[0], expQ[0] & mskQ[0])
		void'(expQ.pop_front());
		void'(mskQ.pop_front());
	end
	task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d);
		@(posedge clk);
		{read, write, address, writedata} <= {!w, w, a, d};
		// Only the watchdog ends a wait that never gets its answer
		do @(posedge clk); while (waitrequest !== 1'b0);
		got = readdata;
		{read, write} <= 2'b00;
	endtask
	task automatic rd(input logic [4:0] a, input logic [7:0] e, m = 8'hFF);
		expQ.push_back(e);
		mskQ.push_back(m);
		bus(0, a, 8'h00);
	endtask
	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		bus(1, a, d);
	endtask
	// Counts clocks until a flag rises, bounded
	task automatic wait_flag(input int u, input int lim);
		n = 0;
		while (overflowFlag[u] !== 1'b1 && n < lim) begin @(posedge clk); n++; end
	endtask
	task automatic finish_test;
		$display("checks %0d mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	initial begin #400us; err_total++; finish_test; end
	initial begin
		void'($urandom(1026));
		repeat (10) @(posedge clk);
		rst_n <= 1;
		rd(5'h0E, 8'h08);
		rd(5'h11, 8'h08);
		rd(5'h1F, 8'h00);
		rd(5'h12, 8'h00);
		$display("reset test done");
		for (int i = 0; i < 8; i++) begin
			v = {i[2:1], 6'($urandom) & 6'h2F};
			wr(5'h0E + 5'(3 * i[0]), v);
			rd(5'h0E + 5'(3 * i[0]), v & 8'hD8);
		end
		$display("control test done");
		lo = 8'($urandom);
		hi = 8'($urandom);
		wr(5'h0D, lo);
		wr(5'h0C, hi);
		wr(5'h0D, ~lo);
		rd(5'h0C, hi);
		rd(5'h0D, lo);
		$display("byte test done");
		wr(5'h0D, 8'hF0);
		wr(5'h0C, 8'hFF);
		@(posedge clk) irqEnable <= 2'b01;
		wr(5'h0E, 8'h90);
		wait_flag(0, 400);
		`CHK(n inside {[56:72]}, 1'b1)
		rd(5'h0C, 8'hFF);
		rd(5'h0E, 8'h90);
		`CHK(irqRequest[0], 1'b1)
		@(posedge clk) irqEnable <= 2'b00;
		wr(5'h0E, 8'h80);
		@(posedge clk) flagClear <= 2'b01;
		@(posedge clk) flagClear <= 2'b00;
		@(posedge clk) `CHK({overflowFlag[0], irqRequest[0]}, 2'b00)
		$display("timer test done");
		wr(5'h11, 8'h50);
		k = 3 + $urandom % 8;
		repeat (k) dtc_pin_model_i.pulse(1, 3);
		repeat (10) @(posedge clk);
		rd(5'h0F, 8'h00);
		rd(5'h10, 8'(k));
		wr(5'h11, 8'h80);
		wr(5'h10, 8'hFE);
		wr(5'h0F, 8'hFF);
		wr(5'h11, 8'h90);
		wait_flag(1, 4000);
		`CHK(n inside {[1520:3060]}, 1'b1)
		$display("unit b test done");
		wr(5'h0D, 8'h00);
		wr(5'h0C, 8'h00);
		dtc_pin_model_i.level(0, 1);
		wr(5'h0E, 8'hD8);
		repeat (20) @(posedge clk);
		dtc_pin_model_i.level(0, 0);
		repeat (10) @(posedge clk);
		rd(5'h0C, 8'h00);
		rd(5'h0D, 8'h00);
		dtc_pin_model_i.pulse(0, 40);
		rd(5'h0E, 8'hC8);
		rd(5'h0C, 8'h00);
		rd(5'h0D, 8'h08, 8'hFC);
		v = got;
		dtc_pin_model_i.pulse(0, 40);
		rd(5'h0C, 8'h00);
		rd(5'h0D, v);
		$display("pulse test done");
		finish_test;
	end
endmodule
